// file: src/drive_mode_pkg.sv
package drive_mode_pkg;
  // Object offsets on the plain register port (index, byte address = 4*index)
  localparam logic [3:0] ADDR_MODE_SEL    = 4'h0;
  localparam logic [3:0] ADDR_CONTROL     = 4'h1;
  localparam logic [3:0] ADDR_STATUS      = 4'h2;
  localparam logic [3:0] ADDR_TARGET_VEL  = 4'h3;
  localparam logic [3:0] ADDR_SPECIAL_ACT = 4'h4;
  localparam logic [3:0] ADDR_SPECIAL_SEL = 4'h5;
  localparam logic [3:0] ADDR_VEL_NUM     = 4'h6;
  localparam logic [3:0] ADDR_VEL_DEN     = 4'h7;
  localparam logic [3:0] ADDR_SAVE        = 4'h8;
  localparam logic [3:0] ADDR_SETUP_RES   = 4'h9;
  localparam logic [3:0] ADDR_ACTIVE_MODE = 4'ha;

  localparam logic [7:0] MODE_AUTO_SETUP = 8'hfe;
  localparam logic [7:0] MODE_VELOCITY   = 8'h02;
  localparam logic [7:0] MODE_CLOCK_DIR  = 8'hf7;
  localparam logic [7:0] SPECIAL_ENABLE  = 8'h02;

  localparam int CW_MODE_SPECIFIC = 4;
  localparam int SW_INDEX_FOUND   = 10;
  localparam int SW_SETUP_DONE    = 12;
  localparam int SW_OP_ENABLED    = 2;
  localparam logic [15:0] CW_ENABLE_OP = 16'h000f;

  localparam logic [7:0]  CAT_DRIVE  = 8'h05;
  localparam logic [7:0]  CAT_TUNING = 8'h06;
  localparam logic [15:0] TEST_RPM      = 16'h001e;
  localparam logic [15:0] MAX_RPM_HIGH  = 16'h03e8;
  localparam logic [15:0] MAX_RPM_LOW   = 16'h0064;

  localparam int ADC_BITS      = 12;
  localparam int ADC_FULL_MV   = 10000;
  localparam int DEAD_MV       = 20;
  localparam logic [11:0] DEAD_CODES = 12'(DEAD_MV * 4095 / ADC_FULL_MV);
  localparam logic [11:0] ADC_MID    = 12'h800;

  localparam int SETUP_STEP_CYCLES = 16;

  typedef enum logic [2:0] {
    SU_IDLE = 3'b000, SU_FWD = 3'b001, SU_REV = 3'b011,
    SU_EDGE = 3'b010, SU_STORE = 3'b110, SU_DONE = 3'b111
  } setup_t;
endpackage

// file: src/drive_mode_setup_control.sv
`timescale 1ns/10ps
// What this block does
// - 0xFE in mode object selects auto setup
// - Bit 4 starts setup when selected, enabled
// - Status bit 12 set when setup ends
// - Status bit 10 reports index found
// - Tests run sequentially, reversing direction, edges
// - Success stores parameters in categories 05, 06
// - Value 2 selects velocity with target speed
// - Controlword zero stops the motor
// - Special modes follow release, ignore controlword
// - Activation subindex value 2 enables special
// - Selector 0-F, bit 3 closed loop
// - Codes 2/3 test run 30 rpm cw/ccw
// - Codes 4-7 analog; 6/7 joystick offset
// - Even analog 1000 rpm, odd 100 rpm
// - Special changes apply after save, restart
// - Clock-direction mode driven by inputs
// - Analog mode writes target velocity continuously
// - Normal analog: direction sign, 20 mV deadzone
// - Joystick: mid-scale zero, 20 mV deadzone
// - Scaling factor sets other maximum speeds
// - Digital input 1 is release
// - Test run turns only while released
module drive_mode_setup_control #(
  parameter int ADC_W = drive_mode_pkg::ADC_BITS
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  input  wire logic [3:0]        ADDR,
  input  wire logic [15:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic [15:0]            RDATA,
  input  wire logic              DIN1,
  input  wire logic              STEP_CLK,
  input  wire logic              DIR_IN,
  input  wire logic [ADC_W-1:0]  ANALOG_IN,
  input  wire logic              SETUP_STEP_OK,
  input  wire logic              INDEX_SEEN,
  input  wire logic              RESTART,
  output logic                   OP_ENABLED,
  output logic                   CLOSED_LOOP,
  output logic                   CLOCK_DIR_MODE,
  output logic                   MOTOR_RUN,
  output logic                   MOTOR_DIR,
  output logic [15:0]            SPEED_RPM,
  output logic                   SETUP_DIR,
  output logic                   STORE_REQ,
  output logic [7:0]             STORE_CAT
);
  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] control;
    logic [15:0] target_vel;
    logic [7:0]  act_pend;
    logic [3:0]  sel_pend;
    logic [7:0]  act_saved;
    logic [3:0]  sel_saved;
    logic        special;
    logic [3:0]  sel;
    logic [15:0] vel_num;
    logic [15:0] vel_den;
    logic        op_en;
    drive_mode_pkg::setup_t su;
    logic [4:0]  su_cnt;
    logic        su_done;
    logic        idx_found;
    logic        cw_bit4_q;
    logic [15:0] rdata;
    logic        dir;
    logic        store;
    logic [7:0]  store_cat;
  } state_t;

  state_t s_q, s_d;

  // Dead-zone aware magnitude above a base point
  function automatic logic [ADC_W-1:0] above(input logic [ADC_W-1:0] v, input logic [ADC_W-1:0] base);
    logic [ADC_W-1:0] diff;
    diff = v - base;
    above = (v > base + ADC_W'(drive_mode_pkg::DEAD_CODES)) ? diff : '0;
  endfunction

  logic [ADC_W-1:0] mag;
  logic             neg;
  logic [15:0]      max_rpm;
  logic [31:0]      scaled;
  logic [15:0]      analog_rpm;
  logic [15:0]      status;

  always_comb begin
    max_rpm = s_q.sel[0] ? drive_mode_pkg::MAX_RPM_LOW : drive_mode_pkg::MAX_RPM_HIGH;
    if (s_q.sel[1]) begin
      // Joystick: below mid runs negative
      if (ANALOG_IN < drive_mode_pkg::ADC_MID) begin
        mag = above(drive_mode_pkg::ADC_MID, ANALOG_IN);
        neg = 1'b1;
      end else begin
        mag = above(ANALOG_IN, drive_mode_pkg::ADC_MID);
        neg = 1'b0;
      end
      // Doubling saturates, else a zero input would wrap to zero speed
      mag = mag[ADC_W-1] ? '1 : {mag[ADC_W-2:0], 1'b0};
    end else begin
      mag = above(ANALOG_IN, '0);
      neg = DIR_IN;
    end
    // Full-scale ratio then user scaling; divide by zero treated as unity
    scaled = 32'(mag) * 32'(max_rpm) / 32'((1 << ADC_W) - 1);
    if (s_q.vel_den != 16'h0000)
      scaled = scaled * 32'(s_q.vel_num) / 32'(s_q.vel_den);
    analog_rpm = scaled[15:0];
  end

  always_comb begin
    status = '0;
    status[drive_mode_pkg::SW_OP_ENABLED] = s_q.op_en;
    status[drive_mode_pkg::SW_SETUP_DONE] = s_q.su_done;
    status[drive_mode_pkg::SW_INDEX_FOUND] = s_q.idx_found;
  end

  always_comb begin
    s_d = s_q;
    s_d.store = 1'b0;
    s_d.rdata = '0;
    if (WR) begin
      unique case (ADDR)
        drive_mode_pkg::ADDR_MODE_SEL:    s_d.mode = WDATA[7:0];
        drive_mode_pkg::ADDR_CONTROL:     s_d.control = WDATA;
        drive_mode_pkg::ADDR_TARGET_VEL:  if (!s_q.special) s_d.target_vel = WDATA;
        drive_mode_pkg::ADDR_SPECIAL_ACT: s_d.act_pend = WDATA[7:0];
        drive_mode_pkg::ADDR_SPECIAL_SEL: s_d.sel_pend = WDATA[3:0];
        drive_mode_pkg::ADDR_VEL_NUM:     s_d.vel_num = WDATA;
        drive_mode_pkg::ADDR_VEL_DEN:     s_d.vel_den = WDATA;
        drive_mode_pkg::ADDR_SAVE: begin
          s_d.act_saved = s_q.act_pend;
          s_d.sel_saved = s_q.sel_pend;
        end
        default: ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        drive_mode_pkg::ADDR_MODE_SEL:    s_d.rdata = {8'h00, s_q.mode};
        drive_mode_pkg::ADDR_CONTROL:     s_d.rdata = s_q.control;
        drive_mode_pkg::ADDR_STATUS:      s_d.rdata = status;
        drive_mode_pkg::ADDR_TARGET_VEL:  s_d.rdata = s_q.target_vel;
        drive_mode_pkg::ADDR_SPECIAL_ACT: s_d.rdata = {8'h00, s_q.act_pend};
        drive_mode_pkg::ADDR_SPECIAL_SEL: s_d.rdata = {12'h000, s_q.sel_pend};
        drive_mode_pkg::ADDR_VEL_NUM:     s_d.rdata = s_q.vel_num;
        drive_mode_pkg::ADDR_VEL_DEN:     s_d.rdata = s_q.vel_den;
        drive_mode_pkg::ADDR_SETUP_RES:   s_d.rdata = {14'h0000, s_q.idx_found, s_q.su_done};
        drive_mode_pkg::ADDR_ACTIVE_MODE: s_d.rdata = {11'h000, s_q.special, s_q.sel};
        default:                          s_d.rdata = '0;
      endcase
    end
    // Saved selection is only taken over at restart
    if (RESTART) begin
      s_d.special = (s_q.act_saved == drive_mode_pkg::SPECIAL_ENABLE);
      s_d.sel = s_q.sel_saved;
      s_d.op_en = 1'b0;
    end else if (s_q.special) begin
      s_d.op_en = DIN1;
      if (s_q.sel[2])
        s_d.target_vel = analog_rpm;
    end else begin
      s_d.op_en = (s_d.control & drive_mode_pkg::CW_ENABLE_OP) == drive_mode_pkg::CW_ENABLE_OP;
    end
    s_d.cw_bit4_q = s_q.control[drive_mode_pkg::CW_MODE_SPECIFIC];
    s_d.dir = neg;

    unique case (s_q.su)
      drive_mode_pkg::SU_IDLE:
        if (!s_q.special && s_q.mode == drive_mode_pkg::MODE_AUTO_SETUP && s_q.op_en
            && s_q.control[drive_mode_pkg::CW_MODE_SPECIFIC] && !s_q.cw_bit4_q) begin
          s_d.su = drive_mode_pkg::SU_FWD;
          s_d.su_cnt = '0;
          s_d.su_done = 1'b0;
          s_d.idx_found = 1'b0;
        end
      drive_mode_pkg::SU_FWD, drive_mode_pkg::SU_REV, drive_mode_pkg::SU_EDGE: begin
        // Each test in turn: forward, reversed, then edge re-evaluation
        s_d.su_cnt = s_q.su_cnt + 5'd1;
        if (INDEX_SEEN)
          s_d.idx_found = 1'b1;
        if (!s_q.op_en) begin
          s_d.su = drive_mode_pkg::SU_IDLE;
        end else if (s_q.su_cnt == 5'(drive_mode_pkg::SETUP_STEP_CYCLES - 1)) begin
          s_d.su_cnt = '0;
          unique case (s_q.su)
            drive_mode_pkg::SU_FWD: s_d.su = drive_mode_pkg::SU_REV;
            drive_mode_pkg::SU_REV: s_d.su = drive_mode_pkg::SU_EDGE;
            default: s_d.su = SETUP_STEP_OK ? drive_mode_pkg::SU_STORE : drive_mode_pkg::SU_DONE;
          endcase
        end
      end
      drive_mode_pkg::SU_STORE: begin
        // Drive category first, tuning second; the count picks the slot
        s_d.store = 1'b1;
        s_d.su_cnt = s_q.su_cnt + 5'd1;
        if (s_q.su_cnt == 5'd0) begin
          s_d.store_cat = drive_mode_pkg::CAT_DRIVE;
        end else begin
          s_d.store_cat = drive_mode_pkg::CAT_TUNING;
          s_d.su = drive_mode_pkg::SU_DONE;
        end
      end
      drive_mode_pkg::SU_DONE: begin
        s_d.store = 1'b0;
        s_d.su_done = 1'b1;
        s_d.su = drive_mode_pkg::SU_IDLE;
      end
      default: s_d.su = drive_mode_pkg::SU_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '{
        mode:       8'h00,
        control:    16'h0000,
        target_vel: 16'h0000,
        act_pend:   8'h00,
        sel_pend:   4'h0,
        act_saved:  8'h00,
        sel_saved:  4'h0,
        special:    1'b0,
        sel:        4'h0,
        vel_num:    16'h0001,
        vel_den:    16'h0001,
        op_en:      1'b0,
        su:         drive_mode_pkg::SU_IDLE,
        su_cnt:     5'h00,
        su_done:    1'b0,
        idx_found:  1'b0,
        cw_bit4_q:  1'b0,
        rdata:      16'h0000,
        dir:        1'b0,
        store:      1'b0,
        store_cat:  drive_mode_pkg::CAT_DRIVE
      };
    end else begin
      s_q <= s_d;
    end
  end

  logic setup_busy;
  assign setup_busy = s_q.su != drive_mode_pkg::SU_IDLE;

  always_comb begin
    RDATA = s_q.rdata;
    OP_ENABLED = s_q.op_en;
    STORE_REQ = s_q.store;
    STORE_CAT = s_q.store_cat;
    SETUP_DIR = (s_q.su == drive_mode_pkg::SU_REV);
    CLOSED_LOOP = s_q.special & s_q.sel[3];
    CLOCK_DIR_MODE = s_q.special && s_q.sel[2:1] == 2'b00;
    MOTOR_RUN = 1'b0;
    MOTOR_DIR = 1'b0;
    SPEED_RPM = 16'h0000;
    if (s_q.special) begin
      if (s_q.sel[2:1] == 2'b01) begin
        MOTOR_RUN = s_q.op_en;
        MOTOR_DIR = s_q.sel[0];
        SPEED_RPM = s_q.op_en ? drive_mode_pkg::TEST_RPM : 16'h0000;
      end else if (s_q.sel[2]) begin
        MOTOR_RUN = s_q.op_en && s_q.target_vel != 16'h0000;
        MOTOR_DIR = s_q.dir;
        SPEED_RPM = s_q.op_en ? s_q.target_vel : 16'h0000;
      end else begin
        MOTOR_RUN = s_q.op_en;
        MOTOR_DIR = DIR_IN;
        SPEED_RPM = {15'h0000, STEP_CLK};
      end
    end else if (setup_busy) begin
      MOTOR_RUN = s_q.op_en;
      MOTOR_DIR = SETUP_DIR;
    end else if (s_q.mode == drive_mode_pkg::MODE_VELOCITY) begin
      MOTOR_RUN = s_q.op_en && s_q.target_vel != 16'h0000;
      SPEED_RPM = s_q.op_en ? s_q.target_vel : 16'h0000;
    end
  end

  AST_RELEASE_FOLLOW: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.special && !RESTART) |=> (s_q.op_en == $past(DIN1))) else $error("Release not followed");
  AST_CW_ZERO_STOP: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (!s_q.special && !RESTART && WR && ADDR == drive_mode_pkg::ADDR_CONTROL && WDATA == 16'h0000)
    |=> !OP_ENABLED && !MOTOR_RUN) else $error("Zero controlword did not stop");
  AST_SETUP_START: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.su == drive_mode_pkg::SU_IDLE && s_d.su == drive_mode_pkg::SU_FWD)
    |-> s_q.mode == 8'hfe && s_q.op_en) else $error("Setup started without preconditions");
  AST_SETUP_DONE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_q.su == drive_mode_pkg::SU_DONE |=> status[12]) else $error("Done bit not set");
  AST_STORE_CATS: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    $rose(STORE_REQ) |-> STORE_CAT == 8'h05 ##1 STORE_REQ && STORE_CAT == 8'h06) else $error("Bad store order");
  AST_TEST_SPEED: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.special && s_q.sel[2:1] == 2'b01) |-> (SPEED_RPM == (OP_ENABLED ? 16'd30 : 16'd0)))
    else $error("Test run speed wrong");
  AST_LOOP_BIT: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CLOSED_LOOP |-> s_q.sel >= 4'h8) else $error("Closed loop for open code");
  AST_RESTART_ONLY: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !RESTART |=> $stable(s_q.special) && $stable(s_q.sel)) else $error("Special mode changed without restart");

  AST_MODE_WRITE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (WR && ADDR == drive_mode_pkg::ADDR_MODE_SEL) |=> s_q.mode == $past(WDATA[7:0]))
    else $error("Mode write lost");

  AST_START_EDGE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.su == drive_mode_pkg::SU_IDLE && s_d.su == drive_mode_pkg::SU_FWD)
    |-> s_q.control[4] && !s_q.cw_bit4_q && !s_q.special) else $error("Setup started without bit 4 edge");

  AST_INDEX_FLAG: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.su inside {drive_mode_pkg::SU_FWD, drive_mode_pkg::SU_REV, drive_mode_pkg::SU_EDGE} && INDEX_SEEN)
    |=> s_q.idx_found) else $error("Index not recorded");

  AST_FWD_THEN_REV: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.su == drive_mode_pkg::SU_FWD && s_q.op_en && s_d.su != drive_mode_pkg::SU_FWD)
    |-> s_d.su == drive_mode_pkg::SU_REV) else $error("Reverse test skipped");

  AST_REV_THEN_EDGE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.su == drive_mode_pkg::SU_REV && s_q.op_en && s_d.su != drive_mode_pkg::SU_REV)
    |-> s_d.su == drive_mode_pkg::SU_EDGE) else $error("Edge test skipped");

  AST_STORE_ONLY_OK: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    $rose(STORE_REQ) |-> $past(SETUP_STEP_OK, 2)) else $error("Store after failed setup");

  AST_VEL_SPEED: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (!s_q.special && !setup_busy && s_q.mode == drive_mode_pkg::MODE_VELOCITY && OP_ENABLED)
    |-> SPEED_RPM == s_q.target_vel) else $error("Velocity speed wrong");

  AST_CTL_IGNORED: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.special && !RESTART && WR && ADDR == drive_mode_pkg::ADDR_CONTROL)
    |=> OP_ENABLED == $past(DIN1)) else $error("Controlword acted in special mode");

  AST_SPECIAL_ACT: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    RESTART |=> s_q.special == ($past(s_q.act_saved) == drive_mode_pkg::SPECIAL_ENABLE))
    else $error("Activation value not honoured");

  AST_SAVE_LATCH: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (WR && ADDR == drive_mode_pkg::ADDR_SAVE) |=> s_q.sel_saved == $past(s_q.sel_pend))
    else $error("Save did not latch selector");

  AST_TEST_DIR: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.special && s_q.sel[2:1] == 2'b01) |-> MOTOR_DIR == s_q.sel[0])
    else $error("Test run direction wrong");

  AST_CLKDIR_PASS: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CLOCK_DIR_MODE |-> MOTOR_DIR == DIR_IN && SPEED_RPM[0] == STEP_CLK)
    else $error("Clock or direction not passed");

  AST_ANALOG_TRACK: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.special && s_q.sel[2] && !RESTART) |=> s_q.target_vel == $past(analog_rpm))
    else $error("Analog target not written");

  AST_DEAD_NORMAL: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.special && s_q.sel[2:1] == 2'b10 && !RESTART && ANALOG_IN <= drive_mode_pkg::DEAD_CODES)
    |=> s_q.target_vel == 16'h0000) else $error("Normal dead zone moved");

  AST_DEAD_JOY: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.special && s_q.sel[2:1] == 2'b11 && !RESTART
     && ANALOG_IN >= drive_mode_pkg::ADC_MID - drive_mode_pkg::DEAD_CODES
     && ANALOG_IN <= drive_mode_pkg::ADC_MID + drive_mode_pkg::DEAD_CODES)
    |=> s_q.target_vel == 16'h0000) else $error("Joystick dead zone moved");

  AST_RELEASE_DROP: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.special && !DIN1 && !RESTART) |=> !OP_ENABLED && !MOTOR_RUN)
    else $error("Drive kept running without release");

  AST_TEST_GATE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (s_q.special && s_q.sel[2:1] == 2'b01) |-> MOTOR_RUN == OP_ENABLED)
    else $error("Test run not gated by release");

  AST_RDATA_IDLE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !RD |=> RDATA == 16'h0000) else $error("Read data held past its cycle");
endmodule

// file: verification/drive_far_side.sv
`timescale 1ns/10ps
module drive_far_side (
  input  wire logic        clk,
  input  wire logic        rel,
  input  wire logic        run,
  input  wire logic        idx,
  input  wire logic [11:0] lvl,
  output logic             din1,
  output logic             step_clk,
  output logic             dir_in,
  output logic [11:0]      ain,
  output logic             step_ok,
  output logic             index_seen
);
  logic [2:0] n_q = 3'h0;
  // Steps only while asked, so the line stands still between runs
  always @(posedge clk) begin
    din1 <= rel;
    ain <= lvl;
    index_seen <= idx;
    step_ok <= 1'b1;
    if (run) begin
      n_q <= n_q + 3'h1;
      step_clk <= n_q[0];
      dir_in <= n_q[2];
    end
  end
  initial begin
    step_clk = 1'b0;
    dir_in = 1'b0;
  end
endmodule

// file: verification/drive_mode_setup_control_bench.sv
`timescale 1ns/10ps
module drive_mode_setup_control_bench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        restart = 1'b0;
  logic        rel = 1'b0;
  logic        run = 1'b0;
  logic        idx = 1'b0;
  logic [11:0] lvl = 12'h000;
  logic [15:0] rdata, speed, tv, mx;
  logic        din1, stepc, dir_in, step_ok, iseen, d0, saw_rev;
  logic [11:0] ain;
  logic        op_en, closed, cdm, mrun, mdir, sdir, sreq;
  logic [7:0]  scat;
  logic [7:0]  cats [$];
  int          fails = 0, check_count = 0, cyc = 0, seed = 32'h9f47, i;
  always #2 clk = ~clk;
  drive_mode_setup_control dut (.REF_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .DIN1(din1), .STEP_CLK(stepc), .DIR_IN(dir_in), .ANALOG_IN(ain),
    .SETUP_STEP_OK(step_ok), .INDEX_SEEN(iseen), .RESTART(restart), .OP_ENABLED(op_en),
    .CLOSED_LOOP(closed), .CLOCK_DIR_MODE(cdm), .MOTOR_RUN(mrun), .MOTOR_DIR(mdir),
    .SPEED_RPM(speed), .SETUP_DIR(sdir), .STORE_REQ(sreq), .STORE_CAT(scat));
  drive_far_side far (.clk(clk), .rel(rel), .run(run), .idx(idx), .lvl(lvl), .din1(din1),
    .step_clk(stepc), .dir_in(dir_in), .ain(ain), .step_ok(step_ok), .index_seen(iseen));
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi, input string m);
    check_count++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s got %h", $time, m, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input string m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e, e, m);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [15:0] top_rpm(input logic [3:0] s);
    return s[0] ? 16'd100 : 16'd1000;
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    if (sdir === 1'b1) saw_rev <= 1'b1;
    if (sreq === 1'b1) cats.push_back(scat);
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end
  initial begin
    saw_rev = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(4'h2, 16'h0000, "status reset");
    rd_reg(4'h6, 16'h0001, "num reset");
    rd_reg(4'hf, 16'h0000, "unmapped");
    $display("test reset done");
    idx <= 1'($random(seed));
    wr_reg(4'h0, 16'h00fe);
    rd_reg(4'h0, 16'h00fe, "mode");
    wr_reg(4'h1, 16'h000f);
    wait_cyc(2);
    chk(op_en, 1, 1, "op en");
    wr_reg(4'h1, 16'h001f);
    wait_cyc(70);
    rd_reg(4'h2, 16'h1004 | (16'(idx) << 10), "setup status");
    chk(saw_rev, 1, 1, "reverse");
    chk(16'(cats.size()), 2, 2, "stores");
    if (cats.size() == 2) chk({cats[0], cats[1]}, 16'h0506, 16'h0506, "cats");
    $display("test setup done");
    wr_reg(4'h0, 16'h0002);
    tv = 16'({$random(seed)} % 500 + 1);
    wr_reg(4'h3, tv);
    wr_reg(4'h1, 16'h000f);
    wait_cyc(3);
    chk({15'h0, mrun}, 1, 1, "vel run");
    chk(speed, tv, tv, "vel speed");
    wr_reg(4'h1, 16'h0000);
    wait_cyc(2);
    chk({15'h0, mrun}, 0, 0, "stop");
    $display("test velocity done");
    rel <= 1'b1;
    for (i = 0; i < 16; i++) begin
      run <= (i[2:1] == 2'b00);
      lvl <= 12'hfff;
      wr_reg(4'h4, 16'h0002);
      wr_reg(4'h5, 16'(i));
      wr_reg(4'h8, 16'h0001);
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      wait_cyc(4);
      chk(closed, i[3], i[3], "loop kind");
      mx = top_rpm(4'(i));
      if (i[2:1] == 2'b00) begin
        chk(cdm, 1, 1, "clkdir");
        chk(mdir, dir_in, dir_in, "dir pass");
        chk(speed[0], stepc, stepc, "step pass");
      end else if (i[2:1] == 2'b01) begin
        chk(speed, 16'd30, 16'd30, "test rpm");
        if (i[0] == 1'b0) d0 = mdir;
        else chk(mdir, !d0, !d0, "test dir");
      end else begin
        chk(speed, mx - 16'd3, mx, "full scale");
        lvl <= i[1] ? 12'(12'h7fc + {$random(seed)} % 9) : 12'({$random(seed)} % 9);
        wait_cyc(3);
        chk(speed, 0, 0, "dead zone");
        if (i[1]) begin
          lvl <= 12'h000;
          wait_cyc(3);
          chk(speed, mx - 16'd3, mx, "joy reverse");
          chk(mdir, 1, 1, "joy sign");
        end
      end
    end
    wr_reg(4'h1, 16'h0000);
    wait_cyc(2);
    chk(op_en, 1, 1, "ctl ignored");
    wr_reg(4'h5, 16'h0004);
    rd_reg(4'ha, 16'h001f, "no restart");
    wr_reg(4'h6, 16'h0002);
    lvl <= 12'hfff;
    wait_cyc(3);
    chk(speed, 16'd194, 16'd200, "scaled");
    rel <= 1'b0;
    wait_cyc(3);
    chk(op_en, 0, 0, "release off");
    chk(mrun, 0, 0, "motor off");
    $display("test special done");
    test_done();
  end
endmodule
